// ---- hw/nmicl_cfg.svh ----
// Purpose: Offsets, field positions and reset values of the NMI/link block
// Assumes: 32-bit APB, word-aligned registers
// Notes:   Definitions only
`ifndef NMICL_CFG_SVH
`define NMICL_CFG_SVH
`define NMICL_OFS_CTRL 12'h000
`define NMICL_OFS_STATUS 12'h004
`define NMICL_OFS_MASK 12'h008
`define NMICL_OFS_STATE 12'h00c
`define NMICL_OFS_CMD 12'h010
`define NMICL_CTRL_RST 8'h04
`define NMICL_C_PAR_EN 0
`define NMICL_C_CHK_EN 1
`define NMICL_C_NMI_MASK 2
`define NMICL_C_KBC_EN 3
`define NMICL_C_SMI 4
`define NMICL_C_PIN_B 5
`define NMICL_S_PAR 0
`define NMICL_S_CHK 1
`define NMICL_S_A20 2
`define NMICL_S_KRST 3
`define NMICL_S_WAKE 4
`define NMICL_S_RX 5
`define NMICL_CMD_STOP 0
`define NMICL_FRAME_DATA 3'h4
`endif

// ---- hw/nmicl_link_if.sv ----
// Purpose: Code hand-off between block logic and the link serialiser
// Assumes: One clock
// Notes:   tx_valid holds until tx_ready is seen high
`timescale 1ns/10ps
`default_nettype none
interface nmicl_link_if;
    import nmicl_pkg::*;
    logic tx_valid;
    nmicl_code_t tx_code;
    logic tx_ready;
    logic rx_valid;
    nmicl_code_t rx_code;
    modport ctl (output tx_valid, output tx_code, input tx_ready,
                 input rx_valid, input rx_code);
    modport phy (input tx_valid, input tx_code, output tx_ready,
                 output rx_valid, output rx_code);
endinterface : nmicl_link_if
`default_nettype wire

// ---- hw/nmicl_link_phy.sv ----
// Purpose: Serial framing of event codes on the control link
// Assumes: Both ends clocked by the shared system clock
// Notes:   Idle low; start bit high, then four code bits LSB first
`timescale 1ns/10ps
`default_nettype none
`include "nmicl_cfg.svh"
module nmicl_link_phy import nmicl_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_rx,
    output logic link_tx,
    nmicl_link_if.phy lnk
);
    nmicl_phy_state_t st_reg;
    nmicl_phy_state_t st_next;
    localparam nmicl_phy_state_t PHY_RST = '{tx_st: ST_IDLE, rx_st: ST_IDLE,
        rx_code: CODE_NONE, tx_sh: 4'h0, tx_cnt: 3'h0, line_tx: 1'b0,
        rx_sh: 4'h0, rx_cnt: 3'h0, rx_valid: 1'b0};

    always_comb begin
        st_next = st_reg;
        st_next.rx_valid = 1'b0;
        if (st_reg.tx_st == ST_IDLE) begin
            st_next.line_tx = 1'b0;
            if (lnk.tx_valid) begin
                st_next.line_tx = 1'b1;
                st_next.tx_sh = lnk.tx_code;
                st_next.tx_cnt = `NMICL_FRAME_DATA;
                st_next.tx_st = ST_BUSY;
            end
        end else begin
            st_next.line_tx = st_reg.tx_sh[0];
            st_next.tx_sh = {1'b0, st_reg.tx_sh[3:1]};
            st_next.tx_cnt = st_reg.tx_cnt - 3'h1;
            if (st_reg.tx_cnt == 3'h1) begin
                st_next.tx_st = ST_IDLE;
            end
        end
        if (st_reg.rx_st == ST_IDLE) begin
            if (link_rx) begin
                st_next.rx_cnt = `NMICL_FRAME_DATA;
                st_next.rx_st = ST_BUSY;
            end
        end else begin
            st_next.rx_sh = {link_rx, st_reg.rx_sh[3:1]};
            st_next.rx_cnt = st_reg.rx_cnt - 3'h1;
            if (st_reg.rx_cnt == 3'h1) begin
                st_next.rx_valid = 1'b1;
                st_next.rx_code = nmicl_code_t'({link_rx, st_reg.rx_sh[3:1]});
                st_next.rx_st = ST_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= PHY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link_tx = st_reg.line_tx;
    assign lnk.tx_ready = (st_reg.tx_st == ST_IDLE);
    assign lnk.rx_valid = st_reg.rx_valid;
    assign lnk.rx_code = st_reg.rx_code;

    chk_frame_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_reg.tx_st == ST_IDLE && lnk.tx_valid)
        |=> link_tx ##4 (st_reg.tx_st == ST_IDLE))
        else $error("link frame not start plus four bits");
endmodule : nmicl_link_phy
`default_nettype wire

// ---- hw/nmicl_pkg.sv ----
// Purpose: Types of the NMI/link block
// Assumes: Codes are four bits, sent after one start bit
// Notes:   Device codes below 8'h8 style range 1..6, partner codes 8..c
package nmicl_pkg;
    typedef enum logic [3:0] {
        CODE_NONE = 4'h0,
        CODE_INTA = 4'h1,
        CODE_CPU_RST = 4'h2,
        CODE_REF_ACK = 4'h3,
        CODE_KBD_IRQ = 4'h4,
        CODE_A20_LO = 4'h5,
        CODE_A20_HI = 4'h6,
        CODE_PB5_LO = 4'h8,
        CODE_PB5_HI = 4'h9,
        CODE_REF_REQ = 4'ha,
        CODE_REF_DONE = 4'hb,
        CODE_ADS = 4'hc
    } nmicl_code_t;
    typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} nmicl_phy_st_t;
    typedef struct packed {
        nmicl_phy_st_t tx_st;
        logic [3:0] tx_sh;
        logic [2:0] tx_cnt;
        logic line_tx;
        nmicl_phy_st_t rx_st;
        logic [3:0] rx_sh;
        logic [2:0] rx_cnt;
        logic rx_valid;
        nmicl_code_t rx_code;
    } nmicl_phy_state_t;
endpackage : nmicl_pkg

// ---- hw/nmicl_top.sv ----
// Purpose: NMI gathering, clock strap, SMI, CPU clock wake and control link
// Assumes: All pin inputs synchronous to pclk; APB slave with no wait
// Notes:   Keyboard and mouse controllers sit outside; pins only routed
//
// Operation
// - Channel-check going low sets its flag and requests an NMI.
// - NMI from parity and channel-check, each enabled, then one final mask.
// - NMI pin sampled at system reset fall: high 1X, low 2X.
// - SMI output driven from power management control.
// - CPU interrupt while CPU clock stopped restarts the CPU clock.
// - Send interrupt acknowledge, CPU reset, refresh ack; keyboard interrupt only with keyboard controller on.
// - Keyboard controller off: A20 gate transitions sent over link; a level repeated before its code goes out is sent once.
// - Keyboard controller off: keyboard clock low sends reset-request code.
// - Keyboard controller on: keyboard and mouse pins routed to it.
// - Pin A always input; pins B, C, D always outputs.
`timescale 1ns/10ps
`default_nettype none
`include "nmicl_cfg.svh"
module nmicl_top import nmicl_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic chan_chk_n,
    input wire logic dram_parity_err,
    input wire logic nmi_in,
    output logic nmi_out,
    output logic nmi_oe,
    input wire logic system_reset_in,
    output logic clk_mode_2x,
    output logic sys_mgmt_irq_n,
    input wire logic cpu_intr,
    output logic cpu_clk_run,
    input wire logic inta_evt,
    input wire logic cpu_reset_evt,
    input wire logic refresh_ack_evt,
    input wire logic kbc_irq_evt,
    input wire logic ctrl_link_rx,
    output logic ctrl_link_tx,
    output logic port_b5,
    output logic refresh_req,
    output logic refresh_done,
    output logic addr_strobe,
    input wire logic kbd_data_line_in,
    output logic kbd_data_line_out,
    output logic kbd_data_line_oe,
    input wire logic kbd_clock_line_in,
    output logic kbd_clock_line_out,
    output logic kbd_clock_line_oe,
    input wire logic mouse_data_line_in,
    output logic mouse_data_line_out,
    output logic mouse_data_line_oe,
    input wire logic mouse_clock_line_in,
    output logic mouse_clock_line_out,
    output logic mouse_clock_line_oe,
    output logic [3:0] kbc_line_in,
    input wire logic [3:0] kbc_line_out,
    input wire logic [3:0] kbc_line_oe,
    input wire logic multi_pin_a,
    output logic multi_pin_b,
    output logic multi_pin_c,
    output logic multi_pin_d
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [5:0] status;
        logic [5:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic nmi_out;
        logic nmi_oe;
        logic clk_2x;
        logic rst_d;
        logic chk_d;
        logic kdat_d;
        logic kclk_d;
        logic intr_d;
        logic cpu_clk_run;
        logic smi_n;
        logic [5:0] pend;
        logic tx_valid;
        nmicl_code_t tx_code;
        logic [3:0] last_rx;
        logic port_b5;
        logic ref_req;
        logic ref_done;
        logic ads;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [3:0] kbc_in;
        logic [2:0] pins_bcd;
    } nmicl_state_t;

    localparam nmicl_state_t TOP_RST = '{ctrl: `NMICL_CTRL_RST,
        status: 6'h00, mask: 6'h00, prdata: 32'h0000_0000, pready: 1'b0,
        pslverr: 1'b0, irq: 1'b0, nmi_out: 1'b0, nmi_oe: 1'b0,
        clk_2x: 1'b0, rst_d: 1'b1, chk_d: 1'b1, kdat_d: 1'b1,
        kclk_d: 1'b1, intr_d: 1'b0, cpu_clk_run: 1'b1, smi_n: 1'b1,
        pend: 6'h00, tx_valid: 1'b0, tx_code: CODE_NONE, last_rx: 4'h0,
        port_b5: 1'b0, ref_req: 1'b0, ref_done: 1'b0, ads: 1'b0,
        pin_out: 4'h0, pin_oe: 4'h0, kbc_in: 4'hf, pins_bcd: 3'h0};

    nmicl_state_t st_reg;
    nmicl_state_t st_next;
    nmicl_link_if lnk ();

    nmicl_link_phy u_phy (
        .pclk(pclk),
        .presetn(presetn),
        .link_rx(ctrl_link_rx),
        .link_tx(ctrl_link_tx),
        .lnk(lnk.phy)
    );

    logic [31:0] rd_data;
    logic rd_err;
    logic wr_en;
    logic [5:0] clr_bits;
    logic stop_clk;
    logic kbc_en;
    logic chk_fall;
    logic a20_chg;
    logic kbd_rst;
    logic wake;
    logic [5:0] evt;
    logic [5:0] pend_left;
    logic [2:0] sel;
    logic [3:0] pin_in;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        pin_in = {mouse_clock_line_in, mouse_data_line_in,
                  kbd_clock_line_in, kbd_data_line_in};
        // Bus slave: data prepared in setup, pready high in access
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr == `NMICL_OFS_CTRL) begin
            rd_data = {24'h00_0000, st_reg.ctrl};
        end else if (paddr == `NMICL_OFS_STATUS) begin
            rd_data = {26'h000_0000, st_reg.status};
        end else if (paddr == `NMICL_OFS_MASK) begin
            rd_data = {26'h000_0000, st_reg.mask};
        end else if (paddr == `NMICL_OFS_STATE) begin
            rd_data = {23'h00_0000, multi_pin_a, st_reg.last_rx,
                       st_reg.port_b5, st_reg.cpu_clk_run, st_reg.clk_2x,
                       st_reg.kdat_d};
        end else if (paddr == `NMICL_OFS_CMD) begin
            rd_data = 32'h0000_0000;
        end else begin
            rd_err = 1'b1;
        end
        st_next.pready = psel && !penable;
        st_next.prdata = 32'h0000_0000;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            st_next.prdata = rd_data;
            st_next.pslverr = rd_err;
        end
        wr_en = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
        clr_bits = 6'h00;
        stop_clk = 1'b0;
        if (wr_en) begin
            if (paddr == `NMICL_OFS_CTRL) begin
                st_next.ctrl = pwdata[7:0];
            end else if (paddr == `NMICL_OFS_STATUS) begin
                clr_bits = pwdata[5:0];
            end else if (paddr == `NMICL_OFS_MASK) begin
                st_next.mask = pwdata[5:0];
            end else if (paddr == `NMICL_OFS_CMD) begin
                stop_clk = pwdata[`NMICL_CMD_STOP];
            end
        end

        ////////////////////////////////////////////////////////////////////
        kbc_en = st_reg.ctrl[`NMICL_C_KBC_EN];
        st_next.chk_d = chan_chk_n;
        st_next.kdat_d = kbd_data_line_in;
        st_next.kclk_d = kbd_clock_line_in;
        st_next.intr_d = cpu_intr;
        st_next.rst_d = system_reset_in;
        chk_fall = st_reg.chk_d && !chan_chk_n;
        a20_chg = !kbc_en && (kbd_data_line_in != st_reg.kdat_d);
        kbd_rst = !kbc_en && st_reg.kclk_d && !kbd_clock_line_in;
        wake = cpu_intr && !st_reg.intr_d && !st_reg.cpu_clk_run;
        evt = {lnk.rx_valid, wake, kbd_rst, a20_chg, chk_fall,
               dram_parity_err};
        // New events beat a same-cycle clear
        st_next.status = (st_reg.status & ~clr_bits) | evt;
        st_next.irq = |(st_reg.status & st_reg.mask);
        st_next.nmi_out = ((st_reg.status[`NMICL_S_PAR]
                            && st_reg.ctrl[`NMICL_C_PAR_EN])
                           || (st_reg.status[`NMICL_S_CHK]
                            && st_reg.ctrl[`NMICL_C_CHK_EN]))
                          && !st_reg.ctrl[`NMICL_C_NMI_MASK];
        // pin released during reset so the strap can be read
        st_next.nmi_oe = !system_reset_in;
        if (st_reg.rst_d && !system_reset_in) begin
            st_next.clk_2x = !nmi_in;
        end
        if (stop_clk) begin
            st_next.cpu_clk_run = 1'b0;
        end
        if (wake) begin
            st_next.cpu_clk_run = 1'b1;
        end
        st_next.smi_n = !st_reg.ctrl[`NMICL_C_SMI];
        // pins B to D are always outputs
        st_next.pins_bcd = st_reg.ctrl[`NMICL_C_PIN_B +: 3];

        ////////////////////////////////////////////////////////////////////
        // pins belong to the keyboard controller when enabled
        if (kbc_en) begin
            st_next.pin_out = kbc_line_out;
            st_next.pin_oe = kbc_line_oe;
            st_next.kbc_in = pin_in;
        end else begin
            st_next.pin_out = 4'h0;
            st_next.pin_oe = 4'h0;
            st_next.kbc_in = 4'hf;
        end

        ////////////////////////////////////////////////////////////////////
        // queue device events, lowest bit first
        evt = {a20_chg && kbd_data_line_in, a20_chg && !kbd_data_line_in,
               kbc_irq_evt && kbc_en, refresh_ack_evt,
               cpu_reset_evt || kbd_rst, inta_evt};
        pend_left = st_reg.pend;
        sel = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (st_reg.pend[i]) begin
                sel = 3'(i);
            end
        end
        if (st_reg.tx_valid && lnk.tx_ready) begin
            st_next.tx_valid = 1'b0;
        end
        // A20 edges closer than one frame may arrive reordered
        if ((!st_reg.tx_valid || lnk.tx_ready) && |st_reg.pend) begin
            st_next.tx_valid = 1'b1;
            pend_left[sel] = 1'b0;
            case (sel)
                3'h0: st_next.tx_code = CODE_INTA;
                // reset code makes the partner restart the CPU
                3'h1: st_next.tx_code = CODE_CPU_RST;
                3'h2: st_next.tx_code = CODE_REF_ACK;
                3'h3: st_next.tx_code = CODE_KBD_IRQ;
                3'h4: st_next.tx_code = CODE_A20_LO;
                default: st_next.tx_code = CODE_A20_HI;
            endcase
        end
        st_next.pend = pend_left | evt;

        st_next.ref_req = 1'b0;
        st_next.ref_done = 1'b0;
        st_next.ads = 1'b0;
        if (lnk.rx_valid) begin
            st_next.last_rx = lnk.rx_code;
            case (lnk.rx_code)
                CODE_PB5_LO: st_next.port_b5 = 1'b0;
                CODE_PB5_HI: st_next.port_b5 = 1'b1;
                CODE_REF_REQ: st_next.ref_req = 1'b1;
                CODE_REF_DONE: st_next.ref_done = 1'b1;
                CODE_ADS: st_next.ads = 1'b1;
                default: st_next.ads = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= TOP_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign lnk.tx_valid = st_reg.tx_valid;
    assign lnk.tx_code = st_reg.tx_code;
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq = st_reg.irq;
    assign nmi_out = st_reg.nmi_out;
    assign nmi_oe = st_reg.nmi_oe;
    assign clk_mode_2x = st_reg.clk_2x;
    assign sys_mgmt_irq_n = st_reg.smi_n;
    assign cpu_clk_run = st_reg.cpu_clk_run;
    assign port_b5 = st_reg.port_b5;
    assign refresh_req = st_reg.ref_req;
    assign refresh_done = st_reg.ref_done;
    assign addr_strobe = st_reg.ads;
    assign kbd_data_line_out = st_reg.pin_out[0];
    assign kbd_data_line_oe = st_reg.pin_oe[0];
    assign kbd_clock_line_out = st_reg.pin_out[1];
    assign kbd_clock_line_oe = st_reg.pin_oe[1];
    assign mouse_data_line_out = st_reg.pin_out[2];
    assign mouse_data_line_oe = st_reg.pin_oe[2];
    assign mouse_clock_line_out = st_reg.pin_out[3];
    assign mouse_clock_line_oe = st_reg.pin_oe[3];
    assign kbc_line_in = st_reg.kbc_in;
    assign multi_pin_b = st_reg.pins_bcd[0];
    assign multi_pin_c = st_reg.pins_bcd[1];
    assign multi_pin_d = st_reg.pins_bcd[2];

    ////////////////////////////////////////////////////////////////////////
    default clocking dflt_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_chk_flag_set: assert property (
        $fell(chan_chk_n) |=> st_reg.status[`NMICL_S_CHK])
        else $error("channel-check fall did not set flag");
    chk_nmi_final_mask: assert property (
        st_reg.ctrl[`NMICL_C_NMI_MASK] && $past(st_reg.ctrl[`NMICL_C_NMI_MASK])
        |-> !nmi_out)
        else $error("NMI seen through the final mask");
    chk_nmi_parity_path: assert property (
        (st_reg.status[`NMICL_S_PAR] && st_reg.ctrl[`NMICL_C_PAR_EN]
         && !st_reg.ctrl[`NMICL_C_NMI_MASK]) |=> nmi_out)
        else $error("enabled parity error gave no NMI");
    chk_strap_mode: assert property (
        $fell(system_reset_in) |=> (clk_mode_2x == !$past(nmi_in)))
        else $error("clock mode strap not taken at reset fall");
    chk_smi_follow: assert property (
        $rose(st_reg.ctrl[`NMICL_C_SMI]) |=> !sys_mgmt_irq_n)
        else $error("SMI output does not follow control");
    chk_clk_restart: assert property (
        (!cpu_clk_run && $rose(cpu_intr)) |=> cpu_clk_run)
        else $error("CPU clock not restarted by interrupt");
    chk_a20_report: assert property (
        (!kbc_en && $changed(kbd_data_line_in))
        |-> ##[1:60] (st_reg.tx_valid && (st_reg.tx_code == CODE_A20_LO
                      || st_reg.tx_code == CODE_A20_HI)))
        else $error("A20 transition not sent over link");
    chk_kbd_reset_code: assert property (
        (!kbc_en && $fell(kbd_clock_line_in))
        |-> ##[1:60] (st_reg.tx_valid && st_reg.tx_code == CODE_CPU_RST))
        else $error("keyboard reset not sent over link");
    chk_pin_route: assert property (
        kbc_en && $past(kbc_en) |=> kbd_data_line_oe == $past(kbc_line_oe[0]))
        else $error("keyboard data pin not routed to controller");
    chk_pins_quiet: assert property (
        (!kbc_en && !$past(kbc_en)) |-> (kbd_data_line_oe == 1'b0
         && kbd_clock_line_oe == 1'b0))
        else $error("keyboard pins driven while controller disabled");
endmodule : nmicl_top
`default_nettype wire

// ---- test/nmicl_peer.sv ----
// Purpose: Companion controller model on the far end of the control link
// Assumes: Shared pclk; idle low, start bit, four code bits LSB first
// Notes:   Bench calls send(); decoded codes kept in last_code/n_codes
`timescale 1ns/10ps
`default_nettype none
module nmicl_peer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_good_in,
    input wire logic link_in,
    output logic link_out,
    output logic system_reset_out
);
    logic [3:0] sh;
    logic [3:0] last_code;
    logic cpu_restart;
    int cnt;
    int n_codes;
    initial link_out = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) system_reset_out <= 1'b0;
        else system_reset_out <= !power_good_in;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            n_codes <= 0;
            sh <= 4'h0;
            last_code <= 4'h0;
            cpu_restart <= 1'b0;
        end else if (cnt == 0) begin
            if (link_in) cnt <= 1;
        end else begin
            sh <= {link_in, sh[3:1]};
            cnt <= (cnt == 4) ? 0 : cnt + 1;
            if (cnt == 4) begin
                last_code <= {link_in, sh[3:1]};
                n_codes <= n_codes + 1;
                if ({link_in, sh[3:1]} == 4'h2) cpu_restart <= 1'b1;
            end
        end
    end
    task automatic send(input logic [3:0] c);
        @(posedge pclk) link_out <= 1'b1;
        for (int i = 0; i < 4; i++) @(posedge pclk) link_out <= c[i];
        @(posedge pclk) link_out <= 1'b0;
    endtask : send
endmodule : nmicl_peer
`default_nettype wire

// ---- test/nmicl_top_tb_top.sv ----
// Purpose: Self-checking bench of the NMI and control link block
// Assumes: Wait-free APB slave; peer model on the link
// Notes:   Only mismatches and the verdict are printed
`timescale 1ns/10ps
`default_nettype none
`include "nmicl_cfg.svh"
module nmicl_top_tb_top import nmicl_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, irq, nmi_out, nmi_oe, nmi_w, sysrst, m2x, e;
    logic smi_n, crun, ltx, lrx, pb5, kd_out, kd_oe, md_oe, pb, pc, pd;
    logic chk_n = 1, intr = 0, npull = 1, pgood = 1, kd_in = 1, kc_in = 1;
    logic pa = 0, mi = 1;
    logic [2:0] rxp, xo;
    logic [1:0] xoe;
    logic [3:0] kli, klo = '0, kloe = '0;
    logic [4:0] pu = '0;
    int err_count = 0, n_checks = 0, n0;
    // Pin level: device drives when enabled, strap pull otherwise
    assign nmi_w = nmi_oe ? nmi_out : npull;
    nmicl_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .chan_chk_n(chk_n), .dram_parity_err(pu[0]), .nmi_in(nmi_w),
        .nmi_out(nmi_out), .nmi_oe(nmi_oe), .system_reset_in(sysrst),
        .clk_mode_2x(m2x), .sys_mgmt_irq_n(smi_n), .cpu_intr(intr),
        .cpu_clk_run(crun), .inta_evt(pu[1]), .cpu_reset_evt(pu[2]),
        .refresh_ack_evt(pu[3]), .kbc_irq_evt(pu[4]), .ctrl_link_rx(lrx),
        .ctrl_link_tx(ltx), .port_b5(pb5), .refresh_req(rxp[0]),
        .refresh_done(rxp[1]), .addr_strobe(rxp[2]),
        .kbd_data_line_in(kd_in), .kbd_data_line_out(kd_out),
        .kbd_data_line_oe(kd_oe), .kbd_clock_line_in(kc_in),
        .kbd_clock_line_out(xo[0]), .kbd_clock_line_oe(xoe[0]),
        .mouse_data_line_in(mi), .mouse_data_line_out(xo[1]),
        .mouse_data_line_oe(md_oe), .mouse_clock_line_in(1'b1),
        .mouse_clock_line_out(xo[2]), .mouse_clock_line_oe(xoe[1]),
        .kbc_line_in(kli), .kbc_line_out(klo), .kbc_line_oe(kloe),
        .multi_pin_a(pa), .multi_pin_b(pb), .multi_pin_c(pc),
        .multi_pin_d(pd));
    nmicl_peer peer (.pclk(pclk), .presetn(presetn), .power_good_in(pgood),
        .link_in(ltx), .link_out(lrx), .system_reset_out(sysrst));
    ////////////////////////////////////////////////////////////////////////
    task automatic c(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            $display("[ERR] %0t got %h exp %h", $time, g, x);
            err_count++;
        end
    endtask : c
    task automatic cy(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cy
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) err_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input int k);
        @(posedge pclk) pu[k] <= 1'b1;
        @(posedge pclk) pu[k] <= 1'b0;
    endtask : pulse
    // Waits for the next frame seen by the peer since n0
    task automatic get(input logic [3:0] x);
        int n;
        n = 0;
        while (peer.n_codes == n0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        c(peer.n_codes - n0, 1);
        c(peer.last_code, x);
    endtask : get
    task automatic end_sim();
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////
    task automatic t_nmi();
        apb(0, `NMICL_OFS_CTRL, 0);
        c(q, `NMICL_CTRL_RST);
        apb(0, 12'h0fc, 0);
        c(e, 1);
        apb(1, `NMICL_OFS_MASK, 32'h3f);
        apb(1, `NMICL_OFS_CTRL, 32'h03);
        pulse(0);
        cy(3);
        c({nmi_out, irq}, 2'b11);
        apb(1, `NMICL_OFS_STATUS, 32'h01);
        cy(2);
        c(nmi_out, 0);
        @(posedge pclk) chk_n <= 1'b0;
        cy(3);
        c(nmi_out, 1);
        apb(0, `NMICL_OFS_STATUS, 0);
        c(q[1], 1);
        chk_n <= 1'b1;
        apb(1, `NMICL_OFS_STATUS, 32'h02);
        apb(1, `NMICL_OFS_CTRL, 32'h07);
        pulse(0);
        cy(3);
        c({nmi_out, irq}, 2'b01);
        apb(1, `NMICL_OFS_MASK, 0);
        apb(1, `NMICL_OFS_CTRL, 32'h02);
        pulse(0);
        cy(3);
        c({nmi_out, irq}, 2'b00);
        apb(1, `NMICL_OFS_STATUS, 32'h3f);
    endtask : t_nmi
    task automatic t_misc();
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk) npull <= i[0];
            pgood <= 1'b0;
            repeat (4) @(posedge pclk);
            pgood <= 1'b1;
            cy(5);
            c({m2x, nmi_oe}, {!i[0], 1'b1});
        end
        @(posedge pclk) pa <= 1'b1;
        apb(1, `NMICL_OFS_CTRL, 32'hf4);
        cy(2);
        c({smi_n, pb, pc, pd}, 4'h7);
        apb(0, `NMICL_OFS_STATE, 0);
        c({q[8], q[1]}, 2'b10);
        apb(1, `NMICL_OFS_CTRL, 32'h04);
        cy(2);
        c({smi_n, pb, pc, pd}, 4'h8);
        apb(1, `NMICL_OFS_CMD, 32'h01);
        cy(2);
        c(crun, 0);
        @(posedge pclk) intr <= 1'b1;
        cy(3);
        c(crun, 1);
        intr <= 1'b0;
    endtask : t_misc
    task automatic t_link();
        int n;
        apb(1, `NMICL_OFS_CTRL, 32'h0c);
        for (int k = 1; k < 5; k++) begin
            n0 = peer.n_codes;
            pulse(k);
            get(k[3:0]);
        end
        apb(1, `NMICL_OFS_CTRL, 32'h04);
        for (int i = 0; i < 2; i++) begin
            n0 = peer.n_codes;
            @(posedge pclk) kd_in <= i[0];
            get(i[0] ? CODE_A20_HI : CODE_A20_LO);
        end
        n0 = peer.n_codes;
        @(posedge pclk) kc_in <= 1'b0;
        get(CODE_CPU_RST);
        c(peer.cpu_restart, 1);
        @(posedge pclk) kc_in <= 1'b1;
        peer.send(CODE_PB5_HI);
        cy(4);
        c(pb5, 1);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            peer.send(4'ha + i[3:0]);
            repeat (8) begin
                @(posedge pclk);
                n += rxp[i];
            end
            c(n, 1);
        end
        apb(0, `NMICL_OFS_STATUS, 0);
        c(q[5], 1);
    endtask : t_link
    task automatic t_route();
        apb(1, `NMICL_OFS_CTRL, 32'h0c);
        @(posedge pclk) kd_in <= 1'b0;
        kloe <= 4'hd;
        klo <= 4'ha;
        mi <= 1'b0;
        cy(3);
        c({kli, kd_oe, kd_out, md_oe, xo, xoe}, 12'hab6);
        apb(1, `NMICL_OFS_CTRL, 32'h04);
        cy(2);
        c({kd_oe, md_oe, xo, xoe, kli}, 11'h00f);
    endtask : t_route
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Whole run is a few hundred cycles
    initial begin
        #300000;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cy(1);
        c({smi_n, crun}, 2'b11);
        t_nmi();
        t_misc();
        t_link();
        t_route();
        end_sim();
    end
endmodule : nmicl_top_tb_top
`default_nettype wire
